//--- tcr_pkg.sv
/*
  tcr_pkg: constants for the page-18 threshold and configuration register bank.
  assumes: one 24-bit word per register, six-bit register address within the page.
*/
`default_nettype none
package tcr_pkg;
  localparam int unsigned TCR_DW = 24;
  localparam int unsigned TCR_AW = 6;
  localparam int unsigned TCR_NREG = 10;
  typedef logic [TCR_DW-1:0] tcr_word_t;
  typedef logic [TCR_AW-1:0] tcr_addr_t;
  // register addresses within the page
  localparam tcr_addr_t TCR_A_IZX   = 6'h18;
  localparam tcr_addr_t TCR_A_PRATE = 6'h1c;
  localparam tcr_addr_t TCR_A_IGAIN = 6'h2b;
  localparam tcr_addr_t TCR_A_V1DUR = 6'h2e;
  localparam tcr_addr_t TCR_A_V1LVL = 6'h2f;
  localparam tcr_addr_t TCR_A_V2DUR = 6'h32;
  localparam tcr_addr_t TCR_A_V2LVL = 6'h33;
  localparam tcr_addr_t TCR_A_VZX   = 6'h3a;
  localparam tcr_addr_t TCR_A_CYC   = 6'h3e;
  localparam tcr_addr_t TCR_A_SCALE = 6'h3f;
  // values after reset
  localparam tcr_word_t TCR_R_IZX   = 24'h100000;
  localparam tcr_word_t TCR_R_PRATE = 24'h800000;
  localparam tcr_word_t TCR_R_IGAIN = 24'h143958;
  localparam tcr_word_t TCR_R_V1DUR = 24'h000000;
  localparam tcr_word_t TCR_R_V1LVL = 24'h7fffff;
  localparam tcr_word_t TCR_R_V2DUR = 24'h000000;
  localparam tcr_word_t TCR_R_V2LVL = 24'h7fffff;
  localparam tcr_word_t TCR_R_VZX   = 24'h100000;
  localparam tcr_word_t TCR_R_CYC   = 24'h000064;
  localparam tcr_word_t TCR_R_SCALE = 24'h4ccccc;
  localparam tcr_word_t TCR_R_SAMPLE = 24'h000fa0;
  // table per slot: address, reset, checksum member, dsp-protectable
  localparam tcr_addr_t TCR_ADDR [TCR_NREG] = '{TCR_A_IZX, TCR_A_PRATE, TCR_A_IGAIN,
    TCR_A_V1DUR, TCR_A_V1LVL, TCR_A_V2DUR, TCR_A_V2LVL, TCR_A_VZX, TCR_A_CYC, TCR_A_SCALE};
  localparam tcr_word_t TCR_RST [TCR_NREG] = '{TCR_R_IZX, TCR_R_PRATE, TCR_R_IGAIN,
    TCR_R_V1DUR, TCR_R_V1LVL, TCR_R_V2DUR, TCR_R_V2LVL, TCR_R_VZX, TCR_R_CYC, TCR_R_SCALE};
  localparam logic [TCR_NREG-1:0] TCR_CSUM_FIXED = 10'b10_1111_1111; // slot 8 is conditional
  localparam logic [TCR_NREG-1:0] TCR_DSP_OK     = 10'b10_1111_1111; // slot 8 host only
  localparam int unsigned TCR_SLOT_CYC = 8;
endpackage
`default_nettype wire

//--- tcr_slot.sv
/*
  tcr_slot: one 24-bit configuration word with host and dsp write ports.
  assumes: caller gates the strobes with decode and protection; host write wins.
*/
`timescale 1ns/100ps
`default_nettype none
module tcr_slot #(
  parameter tcr_pkg::tcr_word_t RST_VAL = '0
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // writers
  input  wire logic              host_we,
  input  wire tcr_pkg::tcr_word_t host_wdata,
  input  wire logic              dsp_we,
  input  wire tcr_pkg::tcr_word_t dsp_wdata,
  // stored word
  output logic [23:0]            value
);
  import tcr_pkg::*;
  typedef struct packed {
    tcr_word_t word;
  } tcr_slot_st_t;
  tcr_slot_st_t st_r;
  tcr_slot_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    // host has priority so a configuration write is never silently undone
    if (host_we) begin
      st_nxt.word = host_wdata;
    end else if (dsp_we) begin
      st_nxt.word = dsp_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r.word <= RST_VAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign value = st_r.word;
endmodule
`default_nettype wire

//--- tcr_regs.sv
/*
  tcr_regs: page-18 register bank of an energy front end (thresholds, pulse rate,
  integrator gain, swell settings, line cycle count, gain scale) with checksum
  membership, write protection and reset defaults.
  assumes: serial port logic delivers a decoded six-bit address, read/write strobes
  on core_clk; checksum engine and dsp sit in the same clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module tcr_regs #(
  parameter int unsigned DATA_W = 24,
  parameter int unsigned ADDR_W = 6
) (
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  sys_rst,
  // host register port
  input  wire logic                  host_wr,
  input  wire logic                  host_rd,
  input  wire tcr_pkg::tcr_addr_t    host_addr,
  input  wire tcr_pkg::tcr_word_t    host_wdata,
  output logic [23:0]                host_rdata,
  output logic                       host_rvalid,
  output logic                       host_hit,
  // internal signal processor write port
  input  wire logic                  dsp_wr,
  input  wire tcr_pkg::tcr_addr_t    dsp_addr,
  input  wire tcr_pkg::tcr_word_t    dsp_wdata,
  // protection and mode controls from other pages
  input  wire logic [9:0]            host_protect,
  input  wire logic [9:0]            dsp_protect,
  input  wire logic                  averaging_select_bit,
  input  wire tcr_pkg::tcr_word_t    averaging_sample_total,
  // checksum engine port
  input  wire tcr_pkg::tcr_addr_t    csum_addr,
  output logic [23:0]                csum_word,
  output logic                       csum_member,
  // values to the datapath
  output logic [23:0]                current_zero_cross_threshold,
  output logic [23:0]                energy_pulse_rate,
  output logic [23:0]                coil_integrator_gain,
  output logic [23:0]                voltage1_overvoltage_duration,
  output logic [23:0]                voltage1_overvoltage_level,
  output logic [23:0]                voltage2_overvoltage_duration,
  output logic [23:0]                voltage2_overvoltage_level,
  output logic [23:0]                voltage_zero_cross_threshold,
  output logic [23:0]                line_cycle_total,
  output logic [23:0]                current_gain_cal_factor
);
  import tcr_pkg::*;

  // slot table and port types are built for these sizes only
  if (DATA_W != TCR_DW || ADDR_W != TCR_AW) begin : g_size_check
    $error("tcr_regs: unsupported word or address width");
  end

  typedef struct packed {
    tcr_word_t  rdata;
    logic       rvalid;
    logic       hit;
    tcr_word_t  cword;
    logic       cmem;
  } tcr_st_t;

  tcr_st_t st_r;
  tcr_st_t st_nxt;

  tcr_word_t            val  [TCR_NREG];
  logic [TCR_NREG-1:0]  hsel;
  logic [TCR_NREG-1:0]  dsel;
  logic [TCR_NREG-1:0]  csel;
  logic [TCR_NREG-1:0]  member;

  genvar g;
  generate
    for (g = 0; g < TCR_NREG; g++) begin : g_slot
      assign hsel[g] = (host_addr == TCR_ADDR[g]);
      assign dsel[g] = (dsp_addr == TCR_ADDR[g]);
      assign csel[g] = (csum_addr == TCR_ADDR[g]);
      tcr_slot #(
        .RST_VAL (TCR_RST[g])
      ) u_slot (
        .core_clk   (core_clk),
        .sys_rst    (sys_rst),
        // protected register ignores that writer; cycle count never dsp-protectable
        .host_we    (host_wr && hsel[g] && !host_protect[g]),
        .host_wdata (host_wdata),
        .dsp_we     (dsp_wr && dsel[g] && !(dsp_protect[g] && TCR_DSP_OK[g])),
        .dsp_wdata  (dsp_wdata),
        .value      (val[g])
      );
    end
  endgenerate

  // membership is fixed except for the line cycle count slot
  always_comb begin
    member = TCR_CSUM_FIXED;
    member[TCR_SLOT_CYC] = averaging_select_bit;
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = host_rd;
    st_nxt.hit = host_rd && (|hsel);
    if (host_rd) begin
      st_nxt.rdata = '0;                                // reserved addresses read zero
      for (int i = 0; i < TCR_NREG; i++) begin
        if (hsel[i]) begin
          st_nxt.rdata = val[i];
        end
      end
    end
    st_nxt.cword = '0;
    st_nxt.cmem = 1'b0;
    for (int i = 0; i < TCR_NREG; i++) begin
      if (csel[i]) begin
        st_nxt.cword = val[i];
        st_nxt.cmem = member[i];
      end
    end
    // sample count lives on another page; it is offered at any unmapped address when averaging is off
    if (!averaging_select_bit && !(|csel)) begin
      st_nxt.cword = averaging_sample_total;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r.rdata  <= '0;
      st_r.rvalid <= 1'b0;
      st_r.hit    <= 1'b0;
      st_r.cword  <= '0;
      st_r.cmem   <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign host_rdata  = st_r.rdata;
  assign host_rvalid = st_r.rvalid;
  assign host_hit    = st_r.hit;
  assign csum_word   = st_r.cword;
  assign csum_member = st_r.cmem;

  assign current_zero_cross_threshold  = val[0];
  assign energy_pulse_rate             = val[1];
  assign coil_integrator_gain          = val[2];
  assign voltage1_overvoltage_duration = val[3];
  assign voltage1_overvoltage_level    = val[4];
  assign voltage2_overvoltage_duration = val[5];
  assign voltage2_overvoltage_level    = val[6];
  assign voltage_zero_cross_threshold  = val[7];
  assign line_cycle_total              = val[8];
  assign current_gain_cal_factor       = val[9];
endmodule
`default_nettype wire

//--- tcr_regs_properties.sv
/* tcr_regs_properties: port checks for the page register bank.
   assumes: bound into tcr_regs; one clock, synchronous reset. */
`timescale 1ns/100ps
`default_nettype none
module tcr_regs_properties
  import tcr_pkg::*;
(
  input wire logic core_clk, sys_rst, host_wr, host_rd, host_rvalid, host_hit,
  input wire logic dsp_wr, averaging_select_bit, csum_member,
  input wire logic [9:0] host_protect,
  input wire tcr_pkg::tcr_addr_t host_addr, dsp_addr, csum_addr,
  input wire tcr_pkg::tcr_word_t host_wdata, dsp_wdata, averaging_sample_total,
  input wire logic [23:0] host_rdata, csum_word, current_zero_cross_threshold,
  input wire logic [23:0] voltage_zero_cross_threshold, coil_integrator_gain,
  input wire logic [23:0] line_cycle_total, current_gain_cal_factor
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_rst; $fell(sys_rst) |-> current_zero_cross_threshold == TCR_R_IZX &&
    voltage_zero_cross_threshold == TCR_R_VZX && coil_integrator_gain == TCR_R_IGAIN &&
    current_gain_cal_factor == TCR_R_SCALE; endproperty
  a_rst: assert property (p_rst) else $error("bad reset value");
  property p_wr; host_wr && host_addr == TCR_A_SCALE && !host_protect[9] |=>
    current_gain_cal_factor == $past(host_wdata); endproperty
  a_wr: assert property (p_wr) else $error("host write lost");
  property p_prot; host_wr && host_protect[9] && !dsp_wr |=>
    $stable(current_gain_cal_factor); endproperty
  a_prot: assert property (p_prot) else $error("protected word changed");
  property p_dsp; dsp_wr && dsp_addr == TCR_A_CYC && !host_wr |=>
    line_cycle_total == $past(dsp_wdata); endproperty
  a_dsp: assert property (p_dsp) else $error("cycle count dsp write lost");
  property p_rd; host_rd && host_addr == TCR_A_CYC |=> host_rvalid && host_hit &&
    host_rdata == $past(line_cycle_total); endproperty
  a_rd: assert property (p_rd) else $error("bad read answer");
  property p_cyc; csum_addr == TCR_A_CYC |=> csum_member == $past(averaging_select_bit)
    && csum_word == $past(line_cycle_total); endproperty
  a_cyc: assert property (p_cyc) else $error("cycle count membership");
  property p_mem; csum_addr == TCR_A_IGAIN |=> csum_member &&
    csum_word == $past(coil_integrator_gain); endproperty
  a_mem: assert property (p_mem) else $error("gain not a member");
  property p_smp; csum_addr == 6'h19 && !averaging_select_bit |=> !csum_member &&
    csum_word == $past(averaging_sample_total); endproperty
  a_smp: assert property (p_smp) else $error("sample count word");
  c_dsp: cover property (dsp_wr && dsp_addr == TCR_A_CYC);
  c_prot: cover property (host_wr && host_protect[9]);
  c_avg: cover property (csum_addr == TCR_A_CYC && averaging_select_bit);
endmodule
bind tcr_regs tcr_regs_properties u_tcr_regs_properties (.*);
`default_nettype wire

//--- tcr_host.sv
/* tcr_host: host processor model on the register port.
   assumes: shares core_clk with the bank; caller queues read results. */
`timescale 1ns/100ps
`default_nettype none
module tcr_host (
  input  wire logic              core_clk,
  output var logic               host_wr,
  output var logic               host_rd,
  output var tcr_pkg::tcr_addr_t host_addr,
  output var tcr_pkg::tcr_word_t host_wdata
);
  import tcr_pkg::*;
  initial begin
    {host_wr, host_rd, host_addr, host_wdata} = '0;
  end
  // whole words to mapped places only; released lines are inverted, not left stale
  task automatic wr(input tcr_addr_t a, input tcr_word_t d);
    @(posedge core_clk);
    {host_wr, host_addr, host_wdata} <= {1'b1, a, d};
    @(posedge core_clk);
    {host_wr, host_addr, host_wdata} <= {1'b0, ~a, ~d};
  endtask
  task automatic rd(input tcr_addr_t a);
    @(posedge core_clk);
    {host_rd, host_addr} <= {1'b1, a};
    @(posedge core_clk);
    {host_rd, host_addr} <= {1'b0, ~a};
  endtask
endmodule
`default_nettype wire

//--- tcr_regs_test.sv
/* tcr_regs_test: defaults, writes, protection and dsp writes on the bank.
   assumes: tcr_host on the host port; checker bound from its own file. */
`timescale 1ns/100ps
`default_nettype none
module tcr_regs_test;
  import tcr_pkg::*;
  logic       core_clk, sys_rst, host_wr, host_rd, host_rvalid, host_hit, dsp_wr, avg;
  logic [9:0] hprot, dprot, m;
  tcr_addr_t  host_addr, dsp_addr, csum_addr;
  tcr_word_t  host_wdata, dsp_wdata, smp, host_rdata, w, shadow[10], q[$];
  int         err_total = 0, cmp_count = 0;
  logic       hq[$];
  tcr_regs u_tcr_regs (.core_clk, .sys_rst, .host_wr, .host_rd, .host_addr, .host_wdata,
    .host_rdata, .host_rvalid, .host_hit, .dsp_wr, .dsp_addr, .dsp_wdata, .host_protect(hprot),
    .dsp_protect(dprot), .averaging_select_bit(avg), .averaging_sample_total(smp), .csum_addr,
    .csum_word(), .csum_member(), .current_zero_cross_threshold(), .energy_pulse_rate(),
    .coil_integrator_gain(), .voltage1_overvoltage_duration(), .voltage1_overvoltage_level(),
    .voltage2_overvoltage_duration(), .voltage2_overvoltage_level(),
    .voltage_zero_cross_threshold(), .line_cycle_total(), .current_gain_cal_factor());
  tcr_host u_tcr_host (.core_clk, .host_wr, .host_rd, .host_addr, .host_wdata);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic check(input tcr_word_t seen, input tcr_word_t want);
    cmp_count++;
    if (seen !== want) begin
      err_total++;
      $display("mismatch at %0t: read %h, expected %h", $time, seen, want);
    end
  endtask
  always @(posedge core_clk) begin
    if (host_rvalid === 1'b1) begin
      check(host_rdata, q.pop_front());
      check(24'(host_hit), 24'(hq.pop_front()));
    end
  end
  // checksum address sweeps every cycle; averaging mode is drawn at random each cycle, so no slot is sure to meet both modes
  always @(posedge core_clk) {avg, smp, csum_addr} <= {1'($urandom), 24'($urandom), csum_addr + 6'h1};
  task automatic rd_all(input int t);
    for (int i = 0; i < 10; i++) begin
      q.push_back(shadow[i]);
      hq.push_back(1'b1);
      u_tcr_host.rd(TCR_ADDR[i]);
    end
    q.push_back('0);
    hq.push_back(1'b0);
    u_tcr_host.rd(6'h19);
    repeat (2) @(posedge core_clk);
    $display("test %0d done", t);
  endtask
  task automatic results;
    $display("checks %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    results();
  end
  initial begin
    sys_rst = 1'b1;
    {dsp_wr, hprot, dprot, dsp_addr, dsp_wdata} = '0;
    // the sweep counts up from here; left unknown it would never leave x
    csum_addr = '0;
    void'($urandom(32'habee96b7));
    shadow = TCR_RST;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd_all(1);
    for (int p = 0; p < 2; p++) begin
      m = p ? 10'($urandom) : '0;
      hprot <= m;
      for (int i = 0; i < 10; i++) begin
        w = 24'($urandom);
        if (!m[i]) shadow[i] = w;
        u_tcr_host.wr(TCR_ADDR[i], w);
      end
      rd_all(2 + p);
    end
    dprot <= '1;
    for (int i = 0; i < 10; i++) begin
      w = 24'($urandom);
      if (i == TCR_SLOT_CYC) shadow[i] = w;
      @(posedge core_clk);
      {dsp_wr, dsp_addr, dsp_wdata} <= {1'b1, TCR_ADDR[i], w};
      @(posedge core_clk);
      dsp_wr <= 1'b0;
    end
    rd_all(4);
    sys_rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    shadow = TCR_RST;
    rd_all(5);
    results();
  end
endmodule
`default_nettype wire
